// ---- inc/safety_cyc_pkg.sv ----
// Constants shared by the safety cycle and commissioning control block
package safety_cyc_pkg;
  localparam int unsigned CLK_HZ = 32'h017d_7840;
  localparam int unsigned HZ_PER_MHZ = 32'h000f_4240;
  localparam int unsigned CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
  localparam int unsigned CYC_W = 16;
  localparam int unsigned N_ENTRIES = 6;
  localparam logic [15:0] MON_MIN_US = 16'h01f4;
  localparam logic [15:0] MON_MAX_US = 16'h61a8;
  localparam logic [15:0] DEF_UPDATE_US = 16'h03e8;
  localparam logic [15:0] COMPACT_US = 16'h07d0;
  localparam logic [15:0] MON_RESET_US = MON_MIN_US;
  localparam int unsigned ENC_RATIO_SHIFT = 2;
  localparam logic [7:0] SEL_COMM = 8'h5f;
  localparam logic [7:0] SEL_OFF = 8'h00;
  localparam logic [15:0] FV_NO_PARAMS = 16'h0082;
  localparam logic [15:0] FV_FIRST_CHG = 16'h07d3;
  localparam logic [15:0] FV_NONE = 16'h0000;
  localparam logic [15:0] PW_DEFAULT = 16'h0000;
  localparam int unsigned STO_BIT = 0;
endpackage

// ---- inc/tick_if.sv ----
// Interface between the cycle tick generator and its controller
`timescale 1ns/10ps
interface tick_if #(parameter int unsigned W = 16);
  logic [W-1:0] period_us;
  logic run;
  logic tick;
  modport ctrl (output period_us, output run, input tick);
  modport gen (input period_us, input run, output tick);
endinterface

// ---- design/min_select.sv ----
// Smallest of a group of sampling-time entries
`timescale 1ns/10ps
module min_select #(
  parameter int unsigned N = 6,
  parameter int unsigned W = 16
) (
  // Entries, packed low entry first
  input wire logic [N*W-1:0] entries,
  // Result
  output logic [W-1:0] min_out
);
  if (N < 1 || W < 1) begin : g_bad
    $error("min_select needs at least one entry");
  end

  function automatic logic [W-1:0] min2(input logic [W-1:0] a, input logic [W-1:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  always_comb begin
    min_out = entries[W-1:0];
    for (int i = 1; i < N; i++) begin
      min_out = min2(min_out, entries[i*W +: W]);
    end
  end
endmodule

// ---- design/cycle_ticker.sv ----
// Tick pulse once per programmed period in microseconds
`timescale 1ns/10ps
module cycle_ticker #(
  parameter int unsigned PRE = 25,
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Period and tick
  tick_if.gen t
);
  if (PRE < 1 || PRE > 256 || W < 2) begin : g_bad
    $error("cycle_ticker needs PRE from 1 to 256 and W >= 2");
  end

  logic [7:0] pre_q;
  logic [W-1:0] us_q;
  wire pre_end = (pre_q == 8'(PRE - 1));
  wire us_end = (us_q >= t.period_us - W'(1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
      us_q <= '0;
      t.tick <= 1'b0;
    end else if (!t.run) begin
      pre_q <= '0;
      us_q <= '0;
      t.tick <= 1'b0;
    end else begin
      pre_q <= pre_end ? 8'h00 : pre_q + 8'h01;
      t.tick <= pre_end && us_end;
      if (pre_end) begin
        us_q <= us_end ? '0 : us_q + W'(1);
      end
    end
  end
endmodule

// ---- design/safety_cycle_commissioning_ctrl.sv ----
// Cycle checks, telegram scan timing and safety commissioning control
`timescale 1ns/10ps
module safety_cycle_commissioning_ctrl #(
  parameter int unsigned N = safety_cyc_pkg::N_ENTRIES,
  parameter int unsigned W = safety_cyc_pkg::CYC_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Cycle settings in microseconds, with the extended_mode select
  input wire logic extended_mode,
  input wire logic [W-1:0] extended_monitor_cycle,
  input wire logic [W-1:0] basic_monitor_cycle_view,
  input wire logic [W-1:0] actual_value_cycle_setting,
  input wire logic [W-1:0] controller_sample_times,
  input wire logic [N*W-1:0] module_comm_clock_entries,
  input wire logic [W-1:0] iso_bus_cycle,
  // Configuration straps
  input wire logic telegram_ctrl,
  input wire logic isochronous,
  input wire logic encoder_fitted,
  input wire logic encoderless,
  input wire logic compact_variant,
  // Commissioning inputs
  input wire logic [7:0] commissioning_selector,
  input wire logic params_exist,
  input wire logic param_change,
  input wire logic param_needs_power_on,
  input wire logic fault_ack,
  input wire logic password_write,
  input wire logic [15:0] safety_password_entry,
  input wire logic sto_select,
  // Function enables
  input wire logic [7:0] monitor_enable_field,
  input wire logic brake_ctrl_enable,
  input wire logic brake_configured,
  input wire logic [15:0] stop_one_delay,
  // Cycle results
  output logic [W-1:0] active_monitor_cycle,
  output logic [W-1:0] module_sample_time_view,
  output logic [W-1:0] actual_cycle_eff,
  output logic monitor_range_err,
  output logic cfg_error,
  output logic monitor_tick,
  output logic scan_tick,
  // Commissioning results
  output logic comm_mode,
  output logic commissioning_active_alarm,
  output logic acceptance_required_fault_cu,
  output logic acceptance_required_fault_mm,
  output logic [15:0] fault_value,
  output logic power_cycle_needed,
  output logic pulse_suppress,
  output logic brake_hold,
  output logic [15:0] safety_password,
  // Function states
  output logic safe_torque_off_en,
  output logic safe_brake_control_en,
  output logic safe_stop_one_en,
  output logic safe_stop_one_active
);
  if (N < 1 || W < 16) begin : g_bad
    $error("Need at least one entry and 16-bit cycles");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_multiple(input logic [W-1:0] a, input logic [W-1:0] b);
    is_multiple = (b != '0) && ((a % b) == '0);
  endfunction

  function automatic logic in_range(input logic [W-1:0] v);
    in_range = (v >= W'(safety_cyc_pkg::MON_MIN_US)) && (v <= W'(safety_cyc_pkg::MON_MAX_US));
  endfunction

  // ----------------------------------------------------------------
  // Cycle selection and checks
  // ----------------------------------------------------------------
  logic [W-1:0] mon_q, view_q, eff_q;
  logic range_err_q, cfg_err_q;
  logic [W-1:0] min_w;

  min_select #(.N(N), .W(W)) u_min (
    .entries(module_comm_clock_entries),
    .min_out(min_w)
  );

  wire [W-1:0] mon_raw = extended_mode ? extended_monitor_cycle : basic_monitor_cycle_view;
  wire mon_ok = in_range(mon_raw);
  wire [W-1:0] zero_eff = compact_variant ? W'(safety_cyc_pkg::COMPACT_US) :
                          isochronous ? iso_bus_cycle : W'(safety_cyc_pkg::DEF_UPDATE_US);
  wire set_zero = (actual_value_cycle_setting == '0);
  wire [W-1:0] eff_w = set_zero ? zero_eff : actual_value_cycle_setting;
  wire [W+1:0] ctrl_x4 = (W+2)'(controller_sample_times) << safety_cyc_pkg::ENC_RATIO_SHIFT;
  wire err_mult = telegram_ctrl && !is_multiple(mon_raw, eff_w);
  wire err_enc = encoder_fitted && !encoderless && ({2'b00, eff_w} < ctrl_x4);
  wire err_sensorless = encoderless && (eff_w != controller_sample_times);
  wire err_compact = compact_variant && !set_zero &&
                     (actual_value_cycle_setting != W'(safety_cyc_pkg::COMPACT_US));
  wire err_module = (min_w != mon_raw);
  wire cfg_err_w = !mon_ok || err_mult || err_enc || err_sensorless || err_compact ||
                   err_module;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mon_q <= W'(safety_cyc_pkg::MON_RESET_US);
      view_q <= '0;
      eff_q <= '0;
      range_err_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else begin
      if (mon_ok) begin
        mon_q <= mon_raw;
      end
      range_err_q <= !mon_ok;
      view_q <= min_w;
      eff_q <= eff_w;
      cfg_err_q <= cfg_err_w;
    end
  end

  // ----------------------------------------------------------------
  // Monitoring and telegram scan ticks
  // ----------------------------------------------------------------
  tick_if #(.W(W)) mon_t ();
  logic half_q, mtick_q, stick_q;

  assign mon_t.period_us = mon_q;
  assign mon_t.run = 1'b1;

  cycle_ticker #(.PRE(safety_cyc_pkg::CYC_PER_US), .W(W)) u_tick (
    .clock(clock),
    .arst_n(arst_n),
    .t(mon_t.gen)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= 1'b0;
      mtick_q <= 1'b0;
      stick_q <= 1'b0;
    end else begin
      mtick_q <= mon_t.tick;
      stick_q <= mon_t.tick && half_q;
      if (mon_t.tick) begin
        half_q <= !half_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Commissioning mode
  // ----------------------------------------------------------------
  logic comm_q, alarm_q, fcu_q, fmm_q, first_q, pwr_q, supp_q, brake_q;
  logic [15:0] fv_q, pw_q;
  wire sel_comm = (commissioning_selector == safety_cyc_pkg::SEL_COMM);
  wire sel_off = (commissioning_selector == safety_cyc_pkg::SEL_OFF);
  wire enter = sel_comm && !comm_q;
  wire leave = comm_q && sel_off;
  wire set_no_par = enter && !params_exist;
  wire set_first = comm_q && !leave && param_change && !first_q;
  wire set_fault = set_no_par || set_first;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      comm_q <= 1'b0;
      alarm_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      if (enter) begin
        comm_q <= 1'b1;
        alarm_q <= 1'b1;
        first_q <= 1'b0;
      end else if (leave) begin
        comm_q <= 1'b0;
        alarm_q <= 1'b0;
      end
      if (set_first) begin
        first_q <= 1'b1;
      end
    end
  end

  // Set wins over acknowledge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fcu_q <= 1'b0;
      fmm_q <= 1'b0;
      fv_q <= safety_cyc_pkg::FV_NONE;
    end else if (set_fault) begin
      fcu_q <= 1'b1;
      fmm_q <= 1'b1;
      fv_q <= set_no_par ? safety_cyc_pkg::FV_NO_PARAMS : safety_cyc_pkg::FV_FIRST_CHG;
    end else if (fault_ack) begin
      fcu_q <= 1'b0;
      fmm_q <= 1'b0;
      fv_q <= safety_cyc_pkg::FV_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Password and function enables
  // ----------------------------------------------------------------
  logic sto_en_q, sbc_en_q, ss1_en_q, ss1_act_q;
  logic pend_pwr_q;
  wire sto_w = monitor_enable_field[safety_cyc_pkg::STO_BIT];
  wire ss1_w = (stop_one_delay != 16'h0000);
  wire sbc_w = brake_ctrl_enable && (sto_w || ss1_w);
  wire any_en_w = (monitor_enable_field != 8'h00);
  wire apply = leave || !comm_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pw_q <= safety_cyc_pkg::PW_DEFAULT;
      sto_en_q <= 1'b0;
      sbc_en_q <= 1'b0;
      ss1_en_q <= 1'b0;
      ss1_act_q <= 1'b0;
    end else begin
      if (password_write && comm_q) begin
        pw_q <= safety_password_entry;
      end
      if (apply) begin
        sto_en_q <= sto_w;
        sbc_en_q <= sbc_w;
        ss1_en_q <= ss1_w;
        ss1_act_q <= ss1_w && any_en_w;
      end
    end
  end

  // Power-cycle flag: pending changes reported when the mode ends
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_pwr_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      if (leave) begin
        pend_pwr_q <= 1'b0;
        pwr_q <= pwr_q || pend_pwr_q || (param_change && param_needs_power_on);
      end else if (comm_q && param_change && param_needs_power_on) begin
        pend_pwr_q <= 1'b1;
      end
    end
  end

  // Pulses held for the whole mode, brake too when brake_configured, selection ignored
  wire supp_w = comm_q || enter || (sto_en_q && sto_select);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supp_q <= 1'b1;
      brake_q <= 1'b0;
    end else begin
      supp_q <= supp_w && !leave || (leave && sto_en_q && sto_select);
      brake_q <= brake_configured && supp_w && !leave;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign active_monitor_cycle = mon_q;
  assign module_sample_time_view = view_q;
  assign actual_cycle_eff = eff_q;
  assign monitor_range_err = range_err_q;
  assign cfg_error = cfg_err_q;
  assign monitor_tick = mtick_q;
  assign scan_tick = stick_q;
  assign comm_mode = comm_q;
  assign commissioning_active_alarm = alarm_q;
  assign acceptance_required_fault_cu = fcu_q;
  assign acceptance_required_fault_mm = fmm_q;
  assign fault_value = fv_q;
  assign power_cycle_needed = pwr_q;
  assign pulse_suppress = supp_q;
  assign brake_hold = brake_q;
  assign safety_password = pw_q;
  assign safe_torque_off_en = sto_en_q;
  assign safe_brake_control_en = sbc_en_q;
  assign safe_stop_one_en = ss1_en_q;
  assign safe_stop_one_active = ss1_act_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mon_reject: assert property (@(posedge clock) disable iff (!arst_n)
    !in_range(mon_raw) |=> $stable(mon_q) && range_err_q)
    else $error("Out-of-range monitoring cycle was taken");

  a_min_view: assert property (@(posedge clock) disable iff (!arst_n)
    ##1 (view_q <= $past(module_comm_clock_entries[W-1:0])) &&
    (view_q <= $past(module_comm_clock_entries[N*W-1 -: W])))
    else $error("Module sample time is not the least entry");

  a_default_1ms: assert property (@(posedge clock) disable iff (!arst_n)
    set_zero && !isochronous && !compact_variant |=> eff_q == W'(safety_cyc_pkg::DEF_UPDATE_US))
    else $error("Zero setting did not give 1 ms");

  a_compact_2ms: assert property (@(posedge clock) disable iff (!arst_n)
    set_zero && compact_variant |=> eff_q == W'(safety_cyc_pkg::COMPACT_US))
    else $error("Compact variant zero setting did not give 2 ms");

  a_enc_ratio: assert property (@(posedge clock) disable iff (!arst_n)
    encoder_fitted && !encoderless && ({2'b00, eff_w} < ctrl_x4) |=> cfg_err_q)
    else $error("Short actual cycle not flagged");

  a_scan_twice: assert property (@(posedge clock) disable iff (!arst_n)
    stick_q |-> mtick_q && !half_q)
    else $error("Scan tick not on every second monitor tick");

  a_comm_enter: assert property (@(posedge clock) disable iff (!arst_n)
    enter |=> comm_q && alarm_q && supp_q)
    else $error("Commissioning entry incomplete");

  a_no_params: assert property (@(posedge clock) disable iff (!arst_n)
    set_no_par |=> fcu_q && fmm_q && fv_q == safety_cyc_pkg::FV_NO_PARAMS)
    else $error("Missing-parameter fault not raised");

  a_first_chg: assert property (@(posedge clock) disable iff (!arst_n)
    set_first && !set_no_par |=> fcu_q && fv_q == safety_cyc_pkg::FV_FIRST_CHG)
    else $error("First-change fault not raised");

  a_pulse_hold: assert property (@(posedge clock) disable iff (!arst_n)
    comm_q && !leave |=> supp_q)
    else $error("Pulses enabled during commissioning");

  a_brake_pair: assert property (@(posedge clock) disable iff (!arst_n)
    sbc_en_q |-> sto_en_q || ss1_en_q)
    else $error("Brake control enabled alone");

  a_ss1_gate: assert property (@(posedge clock) disable iff (!arst_n)
    ss1_act_q |-> ss1_en_q && ($stable(ss1_act_q) || $past(any_en_w)))
    else $error("Stop one active without enables");

  a_mult_check: assert property (@(posedge clock) disable iff (!arst_n)
    telegram_ctrl && !is_multiple(mon_raw, eff_w) |=> cfg_err_q)
    else $error("Monitor cycle not a multiple of actual cycle went unflagged");

  a_pw_locked: assert property (@(posedge clock) disable iff (!arst_n)
    password_write && !comm_q |=> $stable(pw_q))
    else $error("Password changed outside commissioning");

  a_sto_follow: assert property (@(posedge clock) disable iff (!arst_n)
    !comm_q |=> sto_en_q == $past(monitor_enable_field[safety_cyc_pkg::STO_BIT]))
    else $error("Torque-off enable does not follow its enable bit");
endmodule

// ---- bench/comm_tool_model.sv ----
// Commissioning tool model driving cycle settings and mode requests
`timescale 1ns/10ps
module comm_tool_model (
  // Clock
  input wire logic clock,
  // Cycle settings
  output logic [15:0] extended_monitor_cycle = 16'h0000,
  output logic [15:0] basic_monitor_cycle_view = 16'h0000,
  output logic [15:0] actual_value_cycle_setting = 16'h0000,
  output logic [15:0] controller_sample_times = 16'h0000,
  output logic [95:0] module_comm_clock_entries = '0,
  // Commissioning requests
  output logic [7:0] commissioning_selector = 8'h00,
  output logic param_change = 1'b0,
  output logic param_needs_power_on = 1'b0,
  output logic fault_ack = 1'b0,
  output logic password_write = 1'b0,
  output logic [15:0] safety_password_entry = 16'h0000
);
  // ----------------------------------------
  // Cycle settings, skew breaks module match
  // ----------------------------------------
  task automatic set_cycles(logic [15:0] mon, act, ctrl, skew, logic [31:0] rnd);
    int slot;
    logic [95:0] ent;
    slot = rnd[7:0] % 6;
    extended_monitor_cycle = mon;
    basic_monitor_cycle_view = mon;
    actual_value_cycle_setting = act;
    controller_sample_times = ctrl;
    for (int i = 0; i < 6; i++) begin
      ent[i*16 +: 16] = (i == slot) ? mon + skew :
        mon + 16'(rnd[i*4 +: 8]) + 16'h0001;
    end
    module_comm_clock_entries = ent;
  endtask

  // ----------------------------------------
  // Requests: 0 change, 1 acknowledge, 2 password
  // ----------------------------------------
  task automatic select(logic [7:0] code);
    commissioning_selector = code;
  endtask

  task automatic pulse(int kind, logic [15:0] val);
    @(posedge clock);
    #1;
    param_change = (kind == 0);
    param_needs_power_on = (kind == 0) && val[0];
    fault_ack = (kind == 1);
    password_write = (kind == 2);
    safety_password_entry = val;
    @(posedge clock);
    #1;
    param_change = 1'b0;
    param_needs_power_on = 1'b0;
    fault_ack = 1'b0;
    password_write = 1'b0;
  endtask
endmodule

// ---- bench/safety_cycle_commissioning_ctrl_tb.sv ----
// Self-checking bench for the safety cycle and commissioning control block
`timescale 1ns/10ps
`define CMP(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module safety_cycle_commissioning_ctrl_tb;
  typedef struct {int id; logic [15:0] v; int due;} note_s;
  localparam int AMC = 0, MST = 1, ACE = 2, FV = 3, PW = 4, RNG = 5, CFG = 6, CM = 7, AL = 8;
  localparam int FC = 9, FM = 10, PS = 11, BH = 12, TQO = 13, BRK = 14, S1E = 15, S1A = 16;
  localparam int PWR = 17;
  string nm [18] = '{"monitor", "module", "actual", "fault value", "password", "range",
    "cfg", "mode", "alarm", "fault cu", "fault mm", "pulses", "brake hold", "torque off",
    "brake ctrl", "stop one en", "stop one act", "power cycle"};
  note_s q [$];
  int cyc = 0, checked = 0, n_mismatch = 0, n = 0;
  logic s1, clock = 0, arst_n = 0;
  logic [31:0] rnd = 32'h7056_9b5a;
  logic [15:0] amc_exp = 16'h01f4, iso_bus_cycle = 16'h0fa0, stop_one_delay = 16'h0000;
  logic extended_mode = 1, telegram_ctrl = 1, isochronous = 0, encoder_fitted = 1;
  logic encoderless = 0, compact_variant = 0, params_exist = 0, sto_select = 0;
  logic brake_ctrl_enable = 0, brake_configured = 1;
  logic [7:0] monitor_enable_field = 8'h00;
  wire logic [15:0] extended_monitor_cycle, basic_monitor_cycle_view, safety_password_entry;
  wire logic [15:0] actual_value_cycle_setting, controller_sample_times;
  wire logic [95:0] module_comm_clock_entries;
  wire logic [7:0] commissioning_selector;
  wire logic param_change, param_needs_power_on, fault_ack, password_write;
  logic [15:0] active_monitor_cycle, module_sample_time_view, actual_cycle_eff;
  logic [15:0] fault_value, safety_password;
  logic monitor_range_err, cfg_error, monitor_tick, scan_tick, comm_mode, brake_hold;
  logic commissioning_active_alarm, acceptance_required_fault_cu, acceptance_required_fault_mm;
  logic power_cycle_needed, pulse_suppress, safe_torque_off_en, safe_brake_control_en;
  logic safe_stop_one_en, safe_stop_one_active;
  wire logic [12:0] flags = {power_cycle_needed, safe_stop_one_active, safe_stop_one_en,
    safe_brake_control_en, safe_torque_off_en, brake_hold, pulse_suppress,
    acceptance_required_fault_mm, acceptance_required_fault_cu, commissioning_active_alarm,
    comm_mode, cfg_error, monitor_range_err};

  comm_tool_model u_tool (.clock, .extended_monitor_cycle, .basic_monitor_cycle_view,
    .actual_value_cycle_setting, .controller_sample_times, .module_comm_clock_entries,
    .commissioning_selector, .param_change, .param_needs_power_on, .fault_ack,
    .password_write, .safety_password_entry);

  safety_cycle_commissioning_ctrl u_dut (.clock, .arst_n, .extended_mode,
    .extended_monitor_cycle, .basic_monitor_cycle_view, .actual_value_cycle_setting,
    .controller_sample_times, .module_comm_clock_entries, .iso_bus_cycle, .telegram_ctrl,
    .isochronous, .encoder_fitted, .encoderless, .compact_variant, .commissioning_selector,
    .params_exist, .param_change, .param_needs_power_on, .fault_ack, .password_write,
    .safety_password_entry, .sto_select, .monitor_enable_field, .brake_ctrl_enable,
    .brake_configured, .stop_one_delay, .active_monitor_cycle, .module_sample_time_view,
    .actual_cycle_eff, .monitor_range_err, .cfg_error, .monitor_tick, .scan_tick, .comm_mode,
    .commissioning_active_alarm, .acceptance_required_fault_cu, .acceptance_required_fault_mm,
    .fault_value, .power_cycle_needed, .pulse_suppress, .brake_hold, .safety_password,
    .safe_torque_off_en, .safe_brake_control_en, .safe_stop_one_en, .safe_stop_one_active);

  // ----------------------------------------
  // Clock, cycle count and result watcher
  // ----------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [15:0] obs(int id);
    case (id)
      AMC: obs = active_monitor_cycle;
      MST: obs = module_sample_time_view;
      ACE: obs = actual_cycle_eff;
      FV: obs = fault_value;
      PW: obs = safety_password;
      default: obs = {15'h0000, flags[id-5]};
    endcase
  endfunction

  always @(negedge clock) begin
    for (int i = 0; i < q.size(); ) begin
      if (q[i].due <= cyc) begin
        `CMP(nm[q[i].id], q[i].v, obs(q[i].id))
        q.delete(i);
      end else begin
        i++;
      end
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  task automatic note(int id, logic [15:0] v, int lat = 1);
    q.push_back('{id, v, cyc + lat});
  endtask

  task automatic step(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge clock);
      k++;
      if (k > 30000) begin
        n_mismatch++;
        final_report();
      end
    end while (monitor_tick !== 1'b1);
  endtask

  task automatic chk_cyc(logic [15:0] mon, act, ctrl, skew, logic [4:0] st, logic [15:0] eff,
    logic err);
    logic rng;
    rng = (mon < safety_cyc_pkg::MON_MIN_US) || (mon > safety_cyc_pkg::MON_MAX_US);
    if (!rng) amc_exp = mon;
    rnd = lfsr(rnd);
    u_tool.set_cycles(mon, act, ctrl, skew, rnd);
    {telegram_ctrl, isochronous, encoder_fitted, encoderless, compact_variant} = st;
    note(MST, mon + skew);
    note(ACE, eff);
    note(RNG, 16'(rng));
    note(CFG, 16'(err | rng));
    note(AMC, amc_exp);
    step(2);
  endtask

  task automatic set_en(logic [7:0] f, logic b, logic [15:0] d, logic [3:0] e);
    monitor_enable_field = f;
    brake_ctrl_enable = b;
    stop_one_delay = d;
    note(TQO, 16'(e[3]), 2);
    note(BRK, 16'(e[2]), 2);
    note(S1E, 16'(e[1]), 2);
    note(S1A, 16'(e[0]), 2);
    step(3);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    u_tool.set_cycles(16'h01f4, 16'h01f4, 16'h007d, 16'h0000, rnd);
    note(AMC, 16'h01f4);
    note(PS, 16'h0001);
    note(CM, 16'h0000);
    note(FV, 16'h0000);
    note(PW, safety_cyc_pkg::PW_DEFAULT);
    step(2);
    arst_n = 1;
    wait_tick(n);
    wait_tick(n);
    s1 = scan_tick;
    `CMP("tick period", 500 * safety_cyc_pkg::CYC_PER_US, n)
    wait_tick(n);
    `CMP("scan alternation", 1'b1, s1 ^ scan_tick)
    $display("test %s done", "ticks");
    step(1);
    chk_cyc(16'h07d0, 16'h03e8, 16'h007d, 16'h0000, 5'b10100, 16'h03e8, 0);
    chk_cyc(16'h05dc, 16'h03e8, 16'h007d, 16'h0000, 5'b10100, 16'h03e8, 1);
    chk_cyc(16'h07d0, 16'h0000, 16'h007d, 16'h0000, 5'b00100, 16'h03e8, 0);
    chk_cyc(16'h1f40, 16'h0000, 16'h007d, 16'h0000, 5'b11100, 16'h0fa0, 0);
    chk_cyc(16'h07d0, 16'h03e8, 16'h00fa, 16'h0000, 5'b10100, 16'h03e8, 0);
    chk_cyc(16'h07d0, 16'h03e8, 16'h00fb, 16'h0000, 5'b10100, 16'h03e8, 1);
    chk_cyc(16'h07d0, 16'h03e8, 16'h03e8, 16'h0000, 5'b10010, 16'h03e8, 0);
    chk_cyc(16'h07d0, 16'h03e8, 16'h01f4, 16'h0000, 5'b10010, 16'h03e8, 1);
    chk_cyc(16'h07d0, 16'h0000, 16'h007d, 16'h0000, 5'b11101, 16'h07d0, 0);
    chk_cyc(16'h07d0, 16'h03e8, 16'h007d, 16'h0000, 5'b10101, 16'h03e8, 1);
    chk_cyc(16'h01f3, 16'h0000, 16'h007d, 16'h0000, 5'b00000, 16'h03e8, 1);
    chk_cyc(16'h01f4, 16'h0000, 16'h007d, 16'h0000, 5'b00000, 16'h03e8, 0);
    chk_cyc(16'h61a8, 16'h0000, 16'h007d, 16'h0000, 5'b00000, 16'h03e8, 0);
    chk_cyc(16'h61a9, 16'h0000, 16'h007d, 16'h0000, 5'b00000, 16'h03e8, 1);
    chk_cyc(16'h07d0, 16'h03e8, 16'h007d, 16'h0001, 5'b10100, 16'h03e8, 1);
    chk_cyc(16'h07d0, 16'h03e8, 16'h007d, 16'h0000, 5'b10100, 16'h03e8, 0);
    $display("test %s done", "cycle checks");
    set_en(8'h01, 1, 16'h0000, 4'b1100);
    set_en(8'h00, 1, 16'h0000, 4'b0000);
    set_en(8'h00, 1, 16'h0005, 4'b0110);
    set_en(8'h02, 0, 16'h0005, 4'b0011);
    set_en(8'h01, 1, 16'h0000, 4'b1100);
    u_tool.pulse(2, 16'h1234);
    note(PW, 16'h0000, 1);
    step(2);
    $display("test %s done", "enables");
    u_tool.select(safety_cyc_pkg::SEL_COMM);
    note(CM, 16'h0001);
    note(AL, 16'h0001);
    note(PS, 16'h0001);
    note(BH, 16'h0001);
    note(FC, 16'h0001);
    note(FM, 16'h0001);
    note(FV, safety_cyc_pkg::FV_NO_PARAMS);
    step(2);
    monitor_enable_field = 8'h00;
    sto_select = 1;
    note(PS, 16'h0001, 2);
    step(3);
    sto_select = 0;
    note(PS, 16'h0001, 2);
    note(TQO, 16'h0001, 2);
    step(3);
    u_tool.pulse(1, 16'h0000);
    note(FC, 16'h0000, 0);
    u_tool.pulse(0, 16'h0001);
    note(FC, 16'h0001, 0);
    note(FM, 16'h0001, 0);
    note(FV, safety_cyc_pkg::FV_FIRST_CHG, 0);
    u_tool.pulse(1, 16'h0000);
    u_tool.pulse(0, 16'h0000);
    note(FC, 16'h0000, 0);
    note(FV, 16'h0000, 0);
    u_tool.pulse(2, 16'h00a5);
    note(PW, 16'h00a5, 0);
    u_tool.select(safety_cyc_pkg::SEL_OFF);
    note(CM, 16'h0000);
    note(AL, 16'h0000);
    note(TQO, 16'h0000, 2);
    note(PWR, 16'h0001, 2);
    note(PS, 16'h0000, 2);
    step(3);
    params_exist = 1;
    u_tool.select(safety_cyc_pkg::SEL_COMM);
    note(CM, 16'h0001);
    note(FV, 16'h0000);
    step(2);
    u_tool.select(safety_cyc_pkg::SEL_OFF);
    step(4);
    $display("test %s done", "commissioning");
    final_report();
  end
endmodule
